// ==== logic/bmrc_pkg.sv ====
package bmrc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TRAIN_BAUD    = 9600;
  localparam int unsigned RESET_MIN_MS  = 10;
  localparam int unsigned TRAIN_GAP_MS  = 2;
  // cycles per bit, rounded down
  localparam int unsigned BIT_CYCLES    = CLK_FREQ_HZ / TRAIN_BAUD;
  // least times round up to whole cycles
  localparam int unsigned RESET_CYCLES  =
    (RESET_MIN_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYCLES    =
    (TRAIN_GAP_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 24;
  // ==========================================================
  // training sequence
  localparam logic [7:0] TRAIN_BYTE     = 8'h55;
  localparam logic [1:0] TRAIN_COUNT    = 2'h2;
  localparam logic [3:0] FRAME_BITS     = 4'hA;
  localparam logic [3:0] DATA_BITS      = 4'h8;
  // ==========================================================
  // clock source codes
  localparam logic       CLKSRC_MAIN    = 1'b0;
  localparam logic       CLKSRC_LC_OSC  = 1'b1;
endpackage

// ==== logic/bmrc_link_if.sv ====
`timescale 1ns/10ps
// host-side boot and reset pins plus the uart receive line
interface bmrc_link_if;
  logic safe_boot_select_n; // sampled by device at start-up
  logic reset_oe;           // host drives reset line
  logic reset_o;            // value host drives
  logic reset_n;            // resolved reset level
  logic rxd;                // host to device serial line

  // internal pull-up: an undriven reset line reads high
  assign reset_n = reset_oe ? reset_o : 1'b1;

  modport device (
    input safe_boot_select_n,
    input reset_n,
    input rxd
  );
  modport host (
    output safe_boot_select_n,
    output reset_oe,
    output reset_o,
    output rxd
  );
endinterface

// ==== logic/bmrc_device.sv ====
`timescale 1ns/10ps
// Operation
// - safe boot low at start blocks navigation
// - safe boot selects internal LC oscillator
// - safe boot ignores configuration pins
// - two 0x55 bytes at 9600 open link
// - host waits 2 ms before messages
// - safe boot enables serial flash programming
// - host can force safe boot low
// - reset input only, pulled up
// - reset detected after 10 ms low
// - reset driven high reads inactive
// - system reset also clears real-time clock
// - host resets only in critical cases
// - reset is no enable control
module bmrc_device
  import bmrc_pkg::*;
#(
  parameter int unsigned RESET_HOLD = RESET_CYCLES,
  parameter int unsigned BIT_HOLD   = BIT_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  bmrc_link_if.device     link,
  input  wire logic [3:0] config_pins_in,
  output logic            safe_boot_out,
  output logic            clock_select_out,
  output logic            nav_enable_out,
  output logic [3:0]      config_applied_out,
  output logic            flash_prog_enable_out,
  output logic            comm_ready_out,
  output logic            system_reset_out,
  output logic            rtc_clear_out
);

  // ==========================================================
  // input synchronisers
  logic [1:0] rst_sync_q;
  logic [1:0] sb_sync_q;
  logic [1:0] rx_sync_q;
  // two stages each; only the second stage is read. no reset here, so the
  // pin levels are already settled when chip reset lifts and the very
  // first boot sample sees the real safe boot level
  always_ff @(posedge clock_in) begin
    rst_sync_q <= {rst_sync_q[0], link.reset_n};
    sb_sync_q  <= {sb_sync_q[0], link.safe_boot_select_n};
    rx_sync_q  <= {rx_sync_q[0], link.rxd};
  end
  wire rst_level_n = rst_sync_q[1];
  wire sb_level_n  = sb_sync_q[1];
  wire rx_level    = rx_sync_q[1];

  // ==========================================================
  // reset low filter
  logic [CNT_W-1:0] low_cnt_q;
  logic             sys_rst_q;
  // a high level (pulled up or driven) clears the count
  wire low_done = (low_cnt_q >= CNT_W'(RESET_HOLD - 1));
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      low_cnt_q <= '0;
      sys_rst_q <= 1'b0;
    end else if (rst_level_n) begin
      low_cnt_q <= '0;
      sys_rst_q <= 1'b0;
    end else if (!low_done) begin
      low_cnt_q <= low_cnt_q + CNT_W'(1);
    end else begin
      sys_rst_q <= 1'b1;
    end
  end
  // internal start-up reset: chip reset or detected system reset
  wire start_rst = !rst_n_in || sys_rst_q;

  // ==========================================================
  // boot mode latch, sampled once after start-up release
  logic sampled_q;
  logic safe_q;
  always_ff @(posedge clock_in) begin
    if (start_rst) begin
      sampled_q <= 1'b0;
      safe_q    <= 1'b0;
    end else if (!sampled_q) begin
      sampled_q <= 1'b1;
      safe_q    <= !sb_level_n;
    end
  end

  // mode-dependent outputs, plus system reset and clock clear
  assign safe_boot_out    = safe_q;
  assign clock_select_out = safe_q ? CLKSRC_LC_OSC : CLKSRC_MAIN;
  assign nav_enable_out   = sampled_q && !safe_q;
  assign flash_prog_enable_out = safe_q;
  assign system_reset_out = sys_rst_q;
  assign rtc_clear_out    = sys_rst_q;

  // config pins captured at start only in normal mode
  logic [3:0] cfg_q;
  always_ff @(posedge clock_in) begin
    if (start_rst) begin
      cfg_q <= 4'h0;
    end else if (!sampled_q && sb_level_n) begin
      cfg_q <= config_pins_in;
    end
  end
  assign config_applied_out = safe_q ? 4'h0 : cfg_q;

  // ==========================================================
  // training byte receiver: 8N1, sampled mid-bit
  logic [CNT_W-1:0] bit_cnt_q;
  logic [3:0]       bit_idx_q;
  logic [7:0]       shift_q;
  logic             busy_q;
  logic [1:0]       good_q;
  logic             ready_q;
  wire mid_bit  = (bit_cnt_q == CNT_W'(BIT_HOLD / 2));
  wire bit_end  = (bit_cnt_q == CNT_W'(BIT_HOLD - 1));
  wire last_bit = (bit_idx_q == FRAME_BITS - 4'h1);
  // stop bit completes a frame; a non-0x55 byte restarts the count
  wire byte_done = busy_q && mid_bit && last_bit;
  wire byte_ok   = (shift_q == TRAIN_BYTE) && rx_level;
  always_ff @(posedge clock_in) begin
    if (start_rst || !safe_q) begin
      bit_cnt_q <= '0;
      bit_idx_q <= 4'h0;
      shift_q   <= 8'h00;
      busy_q    <= 1'b0;
      good_q    <= 2'h0;
      ready_q   <= 1'b0;
    end else if (!busy_q) begin
      bit_cnt_q <= '0;
      bit_idx_q <= 4'h0;
      busy_q    <= !rx_level && !ready_q;
    end else begin
      bit_cnt_q <= bit_end ? '0 : bit_cnt_q + CNT_W'(1);
      if (mid_bit && bit_idx_q != 4'h0 && bit_idx_q <= DATA_BITS) begin
        shift_q <= {rx_level, shift_q[7:1]}; // lsb first
      end
      if (bit_end) begin
        bit_idx_q <= bit_idx_q + 4'h1;
      end
      if (byte_done) begin
        busy_q <= 1'b0;
        if (!byte_ok) begin
          good_q <= 2'h0;
        end else if (good_q == TRAIN_COUNT - 2'h1) begin
          ready_q <= 1'b1;
        end else begin
          good_q <= good_q + 2'h1;
        end
      end
    end
  end
  // normal mode talks without training
  assign comm_ready_out = safe_q ? ready_q : sampled_q;

endmodule

// ==== logic/bmrc_host.sv ====
`timescale 1ns/10ps
module bmrc_host
  import bmrc_pkg::*;
#(
  parameter int unsigned RESET_HOLD = RESET_CYCLES,
  parameter int unsigned GAP_HOLD   = GAP_CYCLES,
  parameter int unsigned BIT_HOLD   = BIT_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  bmrc_link_if.host link,
  input  wire logic force_safe_in,
  input  wire logic reset_req_in,
  input  wire logic train_req_in,
  output logic      busy_out,
  output logic      msg_allowed_out
);

  typedef enum logic [2:0] {
    BMRC_IDLE  = 3'b000,
    BMRC_RESET = 3'b001,
    BMRC_TRAIN = 3'b010,
    BMRC_GAP   = 3'b011,
    BMRC_OPEN  = 3'b100
  } bmrc_state_t;

  // ==========================================================
  bmrc_state_t      state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [4:0]       bit_q;   // 20 bits = two frames
  logic             allowed_q;
  // frame bits, lsb first: start 0, 0x55, stop 1, twice
  wire [19:0] train_bits = {1'b1, TRAIN_BYTE, 1'b0, 1'b1, TRAIN_BYTE, 1'b0};
  wire bit_end = (cnt_q == CNT_W'(BIT_HOLD - 1));

  // reset pulse is never used as a power switch, held only the minimum
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q   <= BMRC_IDLE;
      cnt_q     <= '0;
      bit_q     <= 5'h00;
      allowed_q <= 1'b0;
    end else begin
      case (state_q)
        BMRC_IDLE: begin
          cnt_q <= '0;
          bit_q <= 5'h00;
          if (reset_req_in) begin
            state_q   <= BMRC_RESET;
            allowed_q <= 1'b0;
          end else if (train_req_in) begin
            state_q   <= BMRC_TRAIN;
            allowed_q <= 1'b0;
          end
        end
        BMRC_RESET: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(RESET_HOLD - 1)) begin
            state_q <= BMRC_IDLE;
          end
        end
        BMRC_TRAIN: begin
          cnt_q <= bit_end ? '0 : cnt_q + CNT_W'(1);
          if (bit_end) begin
            bit_q <= bit_q + 5'h01;
            if (bit_q == 5'd19) begin
              state_q <= BMRC_GAP;
            end
          end
        end
        BMRC_GAP: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(GAP_HOLD - 1)) begin
            state_q   <= BMRC_OPEN;
            allowed_q <= 1'b1;
          end
        end
        BMRC_OPEN: begin
          state_q <= BMRC_IDLE;
        end
        default: state_q <= BMRC_IDLE;
      endcase
    end
  end

  // pin drive: reset driven low in reset, else driven high
  assign link.reset_oe = 1'b1;
  assign link.reset_o  = (state_q != BMRC_RESET);
  assign link.safe_boot_select_n = !force_safe_in;
  assign link.rxd = (state_q == BMRC_TRAIN) ? train_bits[bit_q] : 1'b1;
  assign busy_out        = (state_q != BMRC_IDLE);
  assign msg_allowed_out = allowed_q;

endmodule

// ==== verification/bmrc_monitor.sv ====
`timescale 1ns/10ps
module bmrc_monitor
  import bmrc_pkg::*;
#(
  parameter int unsigned RESET_HOLD = RESET_CYCLES,
  parameter int unsigned GAP_HOLD   = GAP_CYCLES
) (
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic       safe_boot_select_n,
  input wire logic       reset_oe,
  input wire logic       reset_o,
  input wire logic       reset_n,
  input wire logic       rxd,
  input wire logic [3:0] config_applied_out,
  input wire logic       safe_boot_out,
  input wire logic       clock_select_out,
  input wire logic       nav_enable_out,
  input wire logic       flash_prog_enable_out,
  input wire logic       system_reset_out,
  input wire logic       rtc_clear_out,
  input wire logic       msg_allowed_out
);
  // ==========================================================
  // run lengths
  logic [23:0] low_q;
  logic [23:0] idle_q;
  logic        prev_q;
  // low run is held after release so a late reset can be traced
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      low_q  <= 24'h0;
      idle_q <= 24'h0;
      prev_q <= 1'b1;
    end else begin
      prev_q <= reset_n;
      low_q  <= reset_n ? low_q : (prev_q ? 24'h1 : low_q + 24'h1);
      idle_q <= rxd ? idle_q + 24'h1 : 24'h0;
    end
  end
  // ==========================================================
  // checks
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  pull_up_a: assert property (reset_n == (reset_oe ? reset_o : 1'b1))
    else $error("reset line level wrong");
  reset_cause_a: assert property ($rose(system_reset_out) |-> low_q >= RESET_HOLD)
    else $error("reset seen after a short low");
  reset_seen_a: assert property ($changed(low_q) && low_q == RESET_HOLD
    |-> ##[0:8] system_reset_out) else $error("long low missed");
  reset_end_a: assert property ($rose(reset_n) |-> ##[0:8] !system_reset_out)
    else $error("reset stuck after release");
  rtc_clear_a: assert property (rtc_clear_out == system_reset_out)
    else $error("clock clear not tied to reset");
  safe_nav_a: assert property (safe_boot_out |-> !nav_enable_out)
    else $error("navigation in safe boot");
  safe_cfg_a: assert property (safe_boot_out |-> config_applied_out == 4'h0)
    else $error("config applied in safe boot");
  lc_clock_a: assert property (clock_select_out ==
    (safe_boot_out ? CLKSRC_LC_OSC : CLKSRC_MAIN)) else $error("clock source");
  flash_prog_a: assert property (flash_prog_enable_out == safe_boot_out)
    else $error("flash program enable");
  boot_latch_a: assert property (!system_reset_out [*8] |-> $stable(safe_boot_out))
    else $error("boot mode changed");
  msg_gap_a: assert property ($rose(msg_allowed_out) |-> idle_q >= GAP_HOLD)
    else $error("message gap too short");
  cover property ($rose(system_reset_out));
  cover property ($rose(safe_boot_out));
  cover property ($rose(msg_allowed_out));
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
  import bmrc_pkg::*;
  localparam int unsigned RH = 50;
  localparam int unsigned GH = 20;
  // short bit time keeps the run small; the real baud is far slower
  localparam int unsigned BH = 40;
  logic       clock_in, rst_n_in, force_safe, reset_req, train_req;
  logic       busy, msg_ok, safe, csel, nav, fprog, comm, sysrst, rtc;
  logic [3:0] cfg, cfg_app;
  int         fails, n_compared;
  bmrc_link_if link ();
  bmrc_host #(.RESET_HOLD(RH), .GAP_HOLD(GH), .BIT_HOLD(BH)) u_bmrc_host (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link(link),
    .force_safe_in(force_safe), .reset_req_in(reset_req),
    .train_req_in(train_req), .busy_out(busy), .msg_allowed_out(msg_ok));
  bmrc_device #(.RESET_HOLD(RH), .BIT_HOLD(BH)) u_bmrc_device (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link(link),
    .config_pins_in(cfg), .safe_boot_out(safe), .clock_select_out(csel),
    .nav_enable_out(nav), .config_applied_out(cfg_app),
    .flash_prog_enable_out(fprog), .comm_ready_out(comm),
    .system_reset_out(sysrst), .rtc_clear_out(rtc));
  bmrc_monitor #(.RESET_HOLD(RH), .GAP_HOLD(GH)) u_bmrc_monitor (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .safe_boot_select_n(link.safe_boot_select_n),
    .reset_oe(link.reset_oe), .reset_o(link.reset_o),
    .reset_n(link.reset_n), .rxd(link.rxd), .config_applied_out(cfg_app),
    .safe_boot_out(safe), .clock_select_out(csel), .nav_enable_out(nav),
    .flash_prog_enable_out(fprog), .system_reset_out(sysrst),
    .rtc_clear_out(rtc), .msg_allowed_out(msg_ok));
  // ==========================================================
  // helpers
  task automatic check(input logic [3:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic check_mode(input logic s, input logic [3:0] c);
    check({3'h0, safe}, {3'h0, s}, "safe boot");
    check({3'h0, csel}, {3'h0, s}, "clock source");
    check({3'h0, nav}, {3'h0, !s}, "navigation");
    check({3'h0, fprog}, {3'h0, s}, "flash program");
    check(cfg_app, s ? 4'h0 : c, "config");
  endtask
  task automatic pulse(ref logic r);
    @(negedge clock_in) r = 1'b1;
    @(negedge clock_in) r = 1'b0;
  endtask
  // bounded wait so a dead handshake cannot hang the run
  task automatic wait_for(ref logic s, input int lim, input string what);
    int k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge clock_in);
      k++;
    end
    check({3'h0, s}, 4'h1, what);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, tests
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // the tests take about 920 cycles; allow five thousand
  initial begin
    #50_000;
    fails++;
    report_and_stop();
  end
  initial begin
    rst_n_in = 1'b0;
    force_safe = 1'b0;
    reset_req = 1'b0;
    train_req = 1'b0;
    cfg = 4'hA;
    fails = 0;
    n_compared = 0;
    repeat (10) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge clock_in);
    check_mode(1'b0, 4'hA);
    check({3'h0, comm}, 4'h1, "link open in normal mode");
    cfg = 4'h5;
    force_safe = 1'b1;
    repeat (5) @(negedge clock_in);
    check_mode(1'b0, 4'hA);
    $display("test normal boot done");
    pulse(reset_req);
    wait_for(sysrst, RH + 20, "reset detect");
    check({3'h0, rtc}, 4'h1, "clock clear");
    repeat (20) @(negedge clock_in);
    check({3'h0, sysrst}, 4'h0, "reset release");
    check_mode(1'b1, 4'h5);
    check({3'h0, comm}, 4'h0, "link closed");
    $display("test reset into safe boot done");
    pulse(train_req);
    wait_for(comm, 21 * BH, "training");
    check({3'h0, msg_ok}, 4'h0, "early message");
    wait_for(msg_ok, BH + GH, "message gap");
    @(negedge clock_in);
    check({3'h0, busy}, 4'h0, "host back idle");
    $display("test training done");
    report_and_stop();
  end
endmodule
